// *** rtl/diff_bias_defs.vh ***
`ifndef DIFF_BIAS_DEFS_VH
`define DIFF_BIAS_DEFS_VH

// magnitude inputs: unsigned, one lsb is 1 % of the reference current
`define MAG_W            16
// bias is half of up to three magnitudes
`define BIAS_W           17
// every setting port carries this many bits
`define SET_W            12
// internal comparison width, in hundredths of a percent of reference
`define LVL_W            27
// scale that turns a percent magnitude into hundredths of a percent
`define PCT_SCALE        27'h000_0064
// the bias is the magnitude sum shifted right by this, i.e. divided by 2
`define BIAS_SHIFT       1

// base sensitivity, percent of reference current
`define BASE_MIN         12'h00A
`define BASE_MAX         12'h032
`define BASE_DEF         12'h014
// first slope, percent of bias current
`define SLOPE1_MIN       12'h00A
`define SLOPE1_MAX       12'h032
`define SLOPE1_DEF       12'h014
// bias position where the second slope starts, percent of reference
`define KNEE_MIN         12'h0C8
`define KNEE_MAX         12'h7D0
`define KNEE_DEF         12'h0C8
// second slope, percent of bias current
`define SLOPE2_MIN       12'h01E
`define SLOPE2_MAX       12'h0C8
`define SLOPE2_DEF       12'h0C8
// unrestrained limit, percent of reference current
`define UNR_MIN          12'h320
`define UNR_MAX          12'h9C4
`define UNR_DEF          12'h320

`endif

// *** rtl/phase_char_eval.v ***
`timescale 1ns/1ps
`include "diff_bias_defs.vh"

// one measuring element: restrained characteristic and unrestrained limit
module phase_char_eval (
    input  wire                 clk_i,
    input  wire                 sys_rst_i,
    input  wire                 eval_i,
    input  wire [`BIAS_W-1:0]   bias_i,
    input  wire [`MAG_W-1:0]    diff_i,
    input  wire [`SET_W-1:0]    base_pct_i,
    input  wire [`SET_W-1:0]    slope1_pct_i,
    input  wire [`SET_W-1:0]    knee_pct_i,
    input  wire [`SET_W-1:0]    slope2_pct_i,
    input  wire [`SET_W-1:0]    unr_pct_i,
    output reg                  restr_o,
    output reg                  unr_o
);

    function [`LVL_W-1:0] max_lvl;
        input [`LVL_W-1:0] a;
        input [`LVL_W-1:0] b;
        begin
            max_lvl = (a > b) ? a : b;
        end
    endfunction

    wire [`LVL_W-1:0] bias_x   = {{(`LVL_W-`BIAS_W){1'b0}}, bias_i};
    wire [`LVL_W-1:0] diff_x   = {{(`LVL_W-`MAG_W){1'b0}}, diff_i};
    wire [`LVL_W-1:0] base_x   = {{(`LVL_W-`SET_W){1'b0}}, base_pct_i};
    wire [`LVL_W-1:0] slope1_x = {{(`LVL_W-`SET_W){1'b0}}, slope1_pct_i};
    wire [`LVL_W-1:0] knee_x   = {{(`LVL_W-`SET_W){1'b0}}, knee_pct_i};
    wire [`LVL_W-1:0] slope2_x = {{(`LVL_W-`SET_W){1'b0}}, slope2_pct_i};
    wire [`LVL_W-1:0] unr_x    = {{(`LVL_W-`SET_W){1'b0}}, unr_pct_i};

    // segment levels in hundredths of a percent of reference current
    wire [`LVL_W-1:0] flat_lvl   = base_x * `PCT_SCALE;
    wire [`LVL_W-1:0] first_lvl  = slope1_x * bias_x;
    wire [`LVL_W-1:0] knee_lvl   = slope1_x * knee_x;
    wire              past_knee  = bias_x > knee_x;
    wire [`LVL_W-1:0] over_knee  = past_knee ? (bias_x - knee_x) : {`LVL_W{1'b0}};
    wire [`LVL_W-1:0] second_lvl = past_knee ? (knee_lvl + slope2_x * over_knee)
                                             : {`LVL_W{1'b0}};
    // threshold is the highest segment at this bias
    wire [`LVL_W-1:0] thr_lvl    = max_lvl(max_lvl(flat_lvl, first_lvl), second_lvl);
    wire [`LVL_W-1:0] diff_lvl   = diff_x * `PCT_SCALE;

    // decisions are taken once per evaluation step and then held
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            restr_o <= 1'b0;
            unr_o   <= 1'b0;
        end else if (eval_i) begin
            restr_o <= diff_lvl > thr_lvl;
            unr_o   <= diff_x > unr_x;
        end
    end

endmodule // phase_char_eval

// *** rtl/differential_bias_characteristic.v ***
// Summary of operation
// - bias per phase is half the sum of shifted winding magnitudes.
// - each phase raises its own restrained start when above the characteristic.
// - base sensitivity in percent of reference, 10 to 50, default 20.
// - first slope in percent of bias, 10 to 50, default 20.
// - second slope start bias in percent of reference, 200 to 2000, default 200.
// - second slope in percent of bias, 30 to 200, default 200.
// - unrestrained limit in percent of reference, 800 to 2500, default 800.
// - per-phase unrestrained start when differential exceeds the limit, bias ignored.
// - the three unrestrained decisions are ORed into one general start.
// - tertiary magnitudes count only in the three-winding variant, else zero.
// - visible restrained starts are suppressed when the user block is active at the result pulse, then held.
`timescale 1ns/1ps
`include "diff_bias_defs.vh"

module differential_bias_characteristic (
    input  wire                 clk_i,
    input  wire                 sys_rst_i,
    // evaluation step strobe with the magnitudes
    input  wire                 mag_valid_i,
    input  wire [`MAG_W-1:0]    diff_mag_phase1_i,
    input  wire [`MAG_W-1:0]    diff_mag_phase2_i,
    input  wire [`MAG_W-1:0]    diff_mag_phase3_i,
    input  wire [`MAG_W-1:0]    primary_shifted_mag_phase1_i,
    input  wire [`MAG_W-1:0]    primary_shifted_mag_phase2_i,
    input  wire [`MAG_W-1:0]    primary_shifted_mag_phase3_i,
    input  wire [`MAG_W-1:0]    secondary_shifted_mag_phase1_i,
    input  wire [`MAG_W-1:0]    secondary_shifted_mag_phase2_i,
    input  wire [`MAG_W-1:0]    secondary_shifted_mag_phase3_i,
    input  wire [`MAG_W-1:0]    tertiary_shifted_mag_phase1_i,
    input  wire [`MAG_W-1:0]    tertiary_shifted_mag_phase2_i,
    input  wire [`MAG_W-1:0]    tertiary_shifted_mag_phase3_i,
    // variant select and settings
    input  wire                 three_winding_i,
    input  wire [`SET_W-1:0]    base_sensitivity_pct_i,
    input  wire [`SET_W-1:0]    first_slope_pct_i,
    input  wire [`SET_W-1:0]    first_slope_bias_limit_pct_i,
    input  wire [`SET_W-1:0]    second_slope_pct_i,
    input  wire [`SET_W-1:0]    unrestrained_limit_pct_i,
    input  wire                 user_block_input_i,
    // results
    output reg                  result_valid_o,
    output reg  [`BIAS_W-1:0]   bias_mag_phase1_o,
    output reg  [`BIAS_W-1:0]   bias_mag_phase2_o,
    output reg  [`BIAS_W-1:0]   bias_mag_phase3_o,
    output reg                  restrained_start_phase1_int_o,
    output reg                  restrained_start_phase2_int_o,
    output reg                  restrained_start_phase3_int_o,
    output reg                  restrained_start_phase1_o,
    output reg                  restrained_start_phase2_o,
    output reg                  restrained_start_phase3_o,
    output reg                  unrestrained_start_phase1_int_o,
    output reg                  unrestrained_start_phase2_int_o,
    output reg                  unrestrained_start_phase3_int_o,
    output reg                  unrestrained_start_phase1_o,
    output reg                  unrestrained_start_phase2_o,
    output reg                  unrestrained_start_phase3_o,
    output reg                  unrestrained_start_general_o,
    output reg                  setting_clamped_o
);

    // limit a setting to its accepted range, step of one
    function [`SET_W-1:0] clamp_set;
        input [`SET_W-1:0] v;
        input [`SET_W-1:0] lo;
        input [`SET_W-1:0] hi;
        begin
            if (v < lo)
                clamp_set = lo;
            else if (v > hi)
                clamp_set = hi;
            else
                clamp_set = v;
        end
    endfunction

    // out-of-range test for the clamp flag
    function out_of_range;
        input [`SET_W-1:0] v;
        input [`SET_W-1:0] lo;
        input [`SET_W-1:0] hi;
        begin
            out_of_range = (v < lo) || (v > hi);
        end
    endfunction

    // half of the sum of three magnitudes, sum kept two bits wider than a magnitude
    function [`BIAS_W-1:0] bias_of;
        input [`MAG_W-1:0] p;
        input [`MAG_W-1:0] s;
        input [`MAG_W-1:0] t;
        reg   [`MAG_W+1:0] sum;
        begin
            sum     = {2'b00, p} + {2'b00, s} + {2'b00, t};
            bias_of = sum[`MAG_W+1:`BIAS_SHIFT];
        end
    endfunction

    // settings, held clamped; they start from their defaults
    reg  [`SET_W-1:0]   base_ff;
    reg  [`SET_W-1:0]   slope1_ff;
    reg  [`SET_W-1:0]   knee_ff;
    reg  [`SET_W-1:0]   slope2_ff;
    reg  [`SET_W-1:0]   unr_ff;
    reg                 clamp_ff;

    wire                nxt_clamp;

    // first stage: bias and differential per phase
    reg                 stage1_ff;
    reg  [`BIAS_W-1:0]  bias1_ff;
    reg  [`BIAS_W-1:0]  bias2_ff;
    reg  [`BIAS_W-1:0]  bias3_ff;
    reg  [`MAG_W-1:0]   diff1_ff;
    reg  [`MAG_W-1:0]   diff2_ff;
    reg  [`MAG_W-1:0]   diff3_ff;
    reg                 stage2_ff;
    // bias of the step now in the evaluators, kept so it leaves with its flags
    reg  [`BIAS_W-1:0]  bias1_dly_ff;
    reg  [`BIAS_W-1:0]  bias2_dly_ff;
    reg  [`BIAS_W-1:0]  bias3_dly_ff;

    wire [`MAG_W-1:0]   tert1;
    wire [`MAG_W-1:0]   tert2;
    wire [`MAG_W-1:0]   tert3;
    wire                restr1;
    wire                restr2;
    wire                restr3;
    wire                unr1;
    wire                unr2;
    wire                unr3;

    // settings follow the ports one clock later, clamped into range
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            base_ff   <= `BASE_DEF;
            slope1_ff <= `SLOPE1_DEF;
            knee_ff   <= `KNEE_DEF;
            slope2_ff <= `SLOPE2_DEF;
            unr_ff    <= `UNR_DEF;
            clamp_ff  <= 1'b0;
        end else begin
            base_ff   <= clamp_set(base_sensitivity_pct_i, `BASE_MIN, `BASE_MAX);
            slope1_ff <= clamp_set(first_slope_pct_i, `SLOPE1_MIN, `SLOPE1_MAX);
            knee_ff   <= clamp_set(first_slope_bias_limit_pct_i, `KNEE_MIN, `KNEE_MAX);
            slope2_ff <= clamp_set(second_slope_pct_i, `SLOPE2_MIN, `SLOPE2_MAX);
            unr_ff    <= clamp_set(unrestrained_limit_pct_i, `UNR_MIN, `UNR_MAX);
            clamp_ff  <= nxt_clamp;
        end
    end

    assign nxt_clamp = out_of_range(base_sensitivity_pct_i, `BASE_MIN, `BASE_MAX)
                     | out_of_range(first_slope_pct_i, `SLOPE1_MIN, `SLOPE1_MAX)
                     | out_of_range(first_slope_bias_limit_pct_i, `KNEE_MIN, `KNEE_MAX)
                     | out_of_range(second_slope_pct_i, `SLOPE2_MIN, `SLOPE2_MAX)
                     | out_of_range(unrestrained_limit_pct_i, `UNR_MIN, `UNR_MAX);

    // tertiary magnitudes contribute nothing in the two-winding variant
    assign tert1 = three_winding_i ? tertiary_shifted_mag_phase1_i : {`MAG_W{1'b0}};
    assign tert2 = three_winding_i ? tertiary_shifted_mag_phase2_i : {`MAG_W{1'b0}};
    assign tert3 = three_winding_i ? tertiary_shifted_mag_phase3_i : {`MAG_W{1'b0}};

    // capture the step: bias per phase and the differential magnitudes
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            stage1_ff <= 1'b0;
            bias1_ff  <= {`BIAS_W{1'b0}};
            bias2_ff  <= {`BIAS_W{1'b0}};
            bias3_ff  <= {`BIAS_W{1'b0}};
            diff1_ff  <= {`MAG_W{1'b0}};
            diff2_ff  <= {`MAG_W{1'b0}};
            diff3_ff  <= {`MAG_W{1'b0}};
        end else begin
            stage1_ff <= mag_valid_i;
            if (mag_valid_i) begin
                bias1_ff <= bias_of(primary_shifted_mag_phase1_i,
                                    secondary_shifted_mag_phase1_i, tert1);
                bias2_ff <= bias_of(primary_shifted_mag_phase2_i,
                                    secondary_shifted_mag_phase2_i, tert2);
                bias3_ff <= bias_of(primary_shifted_mag_phase3_i,
                                    secondary_shifted_mag_phase3_i, tert3);
                diff1_ff <= diff_mag_phase1_i;
                diff2_ff <= diff_mag_phase2_i;
                diff3_ff <= diff_mag_phase3_i;
            end
        end
    end

    // one evaluator per measuring element
    phase_char_eval u_eval_phase1 (
        .clk_i        (clk_i),
        .sys_rst_i    (sys_rst_i),
        .eval_i       (stage1_ff),
        .bias_i       (bias1_ff),
        .diff_i       (diff1_ff),
        .base_pct_i   (base_ff),
        .slope1_pct_i (slope1_ff),
        .knee_pct_i   (knee_ff),
        .slope2_pct_i (slope2_ff),
        .unr_pct_i    (unr_ff),
        .restr_o      (restr1),
        .unr_o        (unr1)
    );

    phase_char_eval u_eval_phase2 (
        .clk_i        (clk_i),
        .sys_rst_i    (sys_rst_i),
        .eval_i       (stage1_ff),
        .bias_i       (bias2_ff),
        .diff_i       (diff2_ff),
        .base_pct_i   (base_ff),
        .slope1_pct_i (slope1_ff),
        .knee_pct_i   (knee_ff),
        .slope2_pct_i (slope2_ff),
        .unr_pct_i    (unr_ff),
        .restr_o      (restr2),
        .unr_o        (unr2)
    );

    phase_char_eval u_eval_phase3 (
        .clk_i        (clk_i),
        .sys_rst_i    (sys_rst_i),
        .eval_i       (stage1_ff),
        .bias_i       (bias3_ff),
        .diff_i       (diff3_ff),
        .base_pct_i   (base_ff),
        .slope1_pct_i (slope1_ff),
        .knee_pct_i   (knee_ff),
        .slope2_pct_i (slope2_ff),
        .unr_pct_i    (unr_ff),
        .restr_o      (restr3),
        .unr_o        (unr3)
    );

    // carry the bias one stage on; back-to-back steps overwrite the first stage
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            bias1_dly_ff <= {`BIAS_W{1'b0}};
            bias2_dly_ff <= {`BIAS_W{1'b0}};
            bias3_dly_ff <= {`BIAS_W{1'b0}};
        end else if (stage1_ff) begin
            bias1_dly_ff <= bias1_ff;
            bias2_dly_ff <= bias2_ff;
            bias3_dly_ff <= bias3_ff;
        end
    end

    // evaluator results are ready one clock after the first stage
    always @(posedge clk_i) begin
        if (sys_rst_i)
            stage2_ff <= 1'b0;
        else
            stage2_ff <= stage1_ff;
    end

    // publish the step; block gating is applied to the visible restrained starts
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            result_valid_o                  <= 1'b0;
            bias_mag_phase1_o               <= {`BIAS_W{1'b0}};
            bias_mag_phase2_o               <= {`BIAS_W{1'b0}};
            bias_mag_phase3_o               <= {`BIAS_W{1'b0}};
            restrained_start_phase1_int_o   <= 1'b0;
            restrained_start_phase2_int_o   <= 1'b0;
            restrained_start_phase3_int_o   <= 1'b0;
            restrained_start_phase1_o       <= 1'b0;
            restrained_start_phase2_o       <= 1'b0;
            restrained_start_phase3_o       <= 1'b0;
            unrestrained_start_phase1_int_o <= 1'b0;
            unrestrained_start_phase2_int_o <= 1'b0;
            unrestrained_start_phase3_int_o <= 1'b0;
            unrestrained_start_phase1_o     <= 1'b0;
            unrestrained_start_phase2_o     <= 1'b0;
            unrestrained_start_phase3_o     <= 1'b0;
            unrestrained_start_general_o    <= 1'b0;
        end else begin
            result_valid_o <= stage2_ff;
            if (stage2_ff) begin
                bias_mag_phase1_o               <= bias1_dly_ff;
                bias_mag_phase2_o               <= bias2_dly_ff;
                bias_mag_phase3_o               <= bias3_dly_ff;
                restrained_start_phase1_int_o   <= restr1;
                restrained_start_phase2_int_o   <= restr2;
                restrained_start_phase3_int_o   <= restr3;
                restrained_start_phase1_o       <= restr1 & ~user_block_input_i;
                restrained_start_phase2_o       <= restr2 & ~user_block_input_i;
                restrained_start_phase3_o       <= restr3 & ~user_block_input_i;
                unrestrained_start_phase1_int_o <= unr1;
                unrestrained_start_phase2_int_o <= unr2;
                unrestrained_start_phase3_int_o <= unr3;
                unrestrained_start_phase1_o     <= unr1;
                unrestrained_start_phase2_o     <= unr2;
                unrestrained_start_phase3_o     <= unr3;
                unrestrained_start_general_o    <= unr1 | unr2 | unr3;
            end
        end
    end

    // flag shows that at least one setting port is being clamped
    always @(posedge clk_i) begin
        if (sys_rst_i)
            setting_clamped_o <= 1'b0;
        else
            setting_clamped_o <= clamp_ff;
    end

endmodule // differential_bias_characteristic

// *** bench/bias_char_assertions.sv ***
`timescale 1ns/1ps
`include "diff_bias_defs.vh"

// port-level checks of the bias characteristic evaluator
module bias_char_checker (
    input wire               clk_i,
    input wire               sys_rst_i,
    input wire               mag_valid_i,
    input wire [`MAG_W-1:0]  primary_shifted_mag_phase1_i,
    input wire [`MAG_W-1:0]  secondary_shifted_mag_phase1_i,
    input wire [`MAG_W-1:0]  tertiary_shifted_mag_phase1_i,
    input wire               three_winding_i,
    input wire               user_block_input_i,
    input wire               result_valid_o,
    input wire [`BIAS_W-1:0] bias_mag_phase1_o,
    input wire               restrained_start_phase1_int_o,
    input wire               restrained_start_phase1_o,
    input wire               unrestrained_start_phase1_int_o,
    input wire               unrestrained_start_phase2_int_o,
    input wire               unrestrained_start_phase3_int_o,
    input wire               unrestrained_start_phase1_o,
    input wire               unrestrained_start_phase2_o,
    input wire               unrestrained_start_phase3_o,
    input wire               unrestrained_start_general_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // a step answers after a fixed three cycles, and only then
    a_valid_latency: assert property (mag_valid_i |-> ##3 result_valid_o)
        else $error("result missing three cycles after a step");
    a_valid_cause: assert property (result_valid_o |-> $past(mag_valid_i, 3))
        else $error("result without a step three cycles before");
    // bias is half the winding sum, tertiary only in the three-winding variant
    a_bias_phase1: assert property (result_valid_o |-> {1'b0, bias_mag_phase1_o} ==
        ((18'($past(primary_shifted_mag_phase1_i, 3)) + $past(secondary_shifted_mag_phase1_i, 3)
        + ($past(three_winding_i, 3) ? $past(tertiary_shifted_mag_phase1_i, 3) : 16'h0000)) >> 1))
        else $error("phase one bias wrong");
    // results stand between result pulses
    a_results_hold: assert property (!result_valid_o && !$past(sys_rst_i) |-> $stable(bias_mag_phase1_o)
        && $stable(restrained_start_phase1_o) && $stable(unrestrained_start_general_o))
        else $error("results moved without a result pulse");
    // the block gates the visible restrained start only
    a_block_gate: assert property (result_valid_o |-> restrained_start_phase1_o ==
        (restrained_start_phase1_int_o && !$past(user_block_input_i)))
        else $error("visible restrained start not gated by block");
    a_visible_int: assert property (restrained_start_phase1_o |-> restrained_start_phase1_int_o)
        else $error("visible start without internal start");
    a_unr_general: assert property (unrestrained_start_general_o == (unrestrained_start_phase1_o
        || unrestrained_start_phase2_o || unrestrained_start_phase3_o))
        else $error("general unrestrained start is not the or of phases");
    a_unr_copy: assert property ({unrestrained_start_phase1_int_o, unrestrained_start_phase2_int_o,
        unrestrained_start_phase3_int_o} == {unrestrained_start_phase1_o,
        unrestrained_start_phase2_o, unrestrained_start_phase3_o})
        else $error("unrestrained starts differ from internal ones");

    c_restr: cover property (result_valid_o && restrained_start_phase1_o);
    c_unr: cover property (result_valid_o && unrestrained_start_general_o);
    c_blocked: cover property (result_valid_o && restrained_start_phase1_int_o && !restrained_start_phase1_o);
endmodule // bias_char_checker

bind differential_bias_characteristic bias_char_checker u_chk (.*);

// *** bench/mag_source.sv ***
`timescale 1ns/1ps

// upstream magnitude source: one step per request, junk between steps
module mag_source (
    input  wire        clk_i,
    input  wire        go_i,
    input  wire [47:0] d_i,
    input  wire [47:0] p_i,
    input  wire [47:0] s_i,
    input  wire [47:0] t_i,
    output reg         mag_valid_o,
    output reg  [47:0] d_o,
    output reg  [47:0] p_o,
    output reg  [47:0] s_o,
    output reg  [47:0] t_o
);
    initial {mag_valid_o, d_o, p_o, s_o, t_o} = 193'h0;
    // present a step at the falling edge, invert stale values otherwise
    always @(negedge clk_i) begin
        mag_valid_o <= go_i;
        if (go_i) begin
            {d_o, p_o, s_o, t_o} <= {d_i, p_i, s_i, t_i};
        end else begin
            {d_o, p_o, s_o, t_o} <= ~{d_o, p_o, s_o, t_o};
        end
    end
endmodule // mag_source

// *** bench/differential_bias_characteristic_bench.sv ***
`timescale 1ns/1ps
`include "diff_bias_defs.vh"

module differential_bias_characteristic_bench;
    typedef struct packed {
        logic [50:0] b;
        logic [9:0]  f;
    } exp_t;
    reg              clk, rst, go, wind3, blk;
    reg [47:0]       d, p, s, t;
    reg [`SET_W-1:0] bs, s1, kn, s2, ul;
    wire             mv, vld, clamped, ug;
    wire [47:0]      md, mp, ms, mt;
    wire [50:0]      bias_w;
    wire [2:0]       ri, rv, ui, uv;
    exp_t            q[$];
    exp_t            e;
    integer          err_total, comparisons;

    mag_source src (.clk_i(clk), .go_i(go), .d_i(d), .p_i(p), .s_i(s), .t_i(t),
        .mag_valid_o(mv), .d_o(md), .p_o(mp), .s_o(ms), .t_o(mt));
    differential_bias_characteristic uut (
        .clk_i(clk), .sys_rst_i(rst), .mag_valid_i(mv),
        .diff_mag_phase1_i(md[15:0]), .diff_mag_phase2_i(md[31:16]),
        .diff_mag_phase3_i(md[47:32]),
        .primary_shifted_mag_phase1_i(mp[15:0]), .primary_shifted_mag_phase2_i(mp[31:16]),
        .primary_shifted_mag_phase3_i(mp[47:32]),
        .secondary_shifted_mag_phase1_i(ms[15:0]), .secondary_shifted_mag_phase2_i(ms[31:16]),
        .secondary_shifted_mag_phase3_i(ms[47:32]),
        .tertiary_shifted_mag_phase1_i(mt[15:0]), .tertiary_shifted_mag_phase2_i(mt[31:16]),
        .tertiary_shifted_mag_phase3_i(mt[47:32]),
        .three_winding_i(wind3), .base_sensitivity_pct_i(bs), .first_slope_pct_i(s1),
        .first_slope_bias_limit_pct_i(kn), .second_slope_pct_i(s2),
        .unrestrained_limit_pct_i(ul), .user_block_input_i(blk), .result_valid_o(vld),
        .bias_mag_phase1_o(bias_w[16:0]), .bias_mag_phase2_o(bias_w[33:17]),
        .bias_mag_phase3_o(bias_w[50:34]),
        .restrained_start_phase1_int_o(ri[0]), .restrained_start_phase2_int_o(ri[1]),
        .restrained_start_phase3_int_o(ri[2]),
        .restrained_start_phase1_o(rv[0]), .restrained_start_phase2_o(rv[1]),
        .restrained_start_phase3_o(rv[2]),
        .unrestrained_start_phase1_int_o(ui[0]), .unrestrained_start_phase2_int_o(ui[1]),
        .unrestrained_start_phase3_int_o(ui[2]),
        .unrestrained_start_phase1_o(uv[0]), .unrestrained_start_phase2_o(uv[1]),
        .unrestrained_start_phase3_o(uv[2]),
        .unrestrained_start_general_o(ug), .setting_clamped_o(clamped));

    // threshold is the largest of flat, first and second slope lines
    function automatic [2:0] exp_r(input [47:0] dd, input [50:0] bb);
        integer i, b, th, base;
        begin
            base = (bs < 10) ? 10 : (bs > 50) ? 50 : bs;
            for (i = 0; i < 3; i = i + 1) begin
                b = bb[i*17+:17];
                th = base * 100;
                if (s1 * b > th) th = s1 * b;
                if (b > kn && s1 * kn + s2 * (b - kn) > th) th = s1 * kn + s2 * (b - kn);
                exp_r[i] = dd[i*16+:16] * 100 > th;
            end
        end
    endfunction

    task cmp_bias(input [50:0] got, input [50:0] want);
        comparisons++;
        if (got !== want) begin
            err_total++;
            $display("unexpected at %0t: bias %h, want %h", $time, got, want);
        end
    endtask
    task cmp_flags(input [9:0] got, input [9:0] want);
        comparisons++;
        if (got !== want) begin
            err_total++;
            $display("unexpected at %0t: flags %b, want %b", $time, got, want);
        end
    endtask

    // queue the expectation and hand one step to the source
    task step(input [47:0] dd, input [47:0] pp, input [47:0] ss, input [47:0] tt);
        integer i, v;
        exp_t x;
        logic [2:0] u;
        begin
            // wait first, so variant, block and settings just driven are seen
            @(negedge clk);
            for (i = 0; i < 3; i = i + 1) begin
                v = pp[i*16+:16] + ss[i*16+:16] + (wind3 ? tt[i*16+:16] : 16'h0000);
                x.b[i*17+:17] = 17'(v >> 1);
                u[i] = dd[i*16+:16] > ul;
            end
            x.f = {exp_r(dd, x.b), exp_r(dd, x.b) & ~{3{blk}}, u, |u};
            q.push_back(x);
            go <= 1'b1;
            {d, p, s, t} <= {dd, pp, ss, tt};
        end
    endtask
    task drain(input string n);
        integer k;
        begin
            @(negedge clk);
            go <= 1'b0;
            for (k = 0; k < 20 && q.size() != 0; k++) @(negedge clk);
            if (q.size() != 0) cmp_flags(10'h3FF, 10'h000);
            $display("test %s finished", n);
        end
    endtask
    task report_and_stop;
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // compare every result pulse against the oldest expectation
    always @(negedge clk) begin
        if (vld === 1'b1) begin
            e = q.pop_front();
            cmp_bias(bias_w, e.b);
            cmp_flags({ri, rv, uv, ug}, e.f);
        end
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #2_000_000;
        err_total++;
        report_and_stop;
    end

    initial begin
        {rst, go, wind3, blk, d, p, s, t} = {1'b1, 196'h0};
        {bs, s1, kn, s2, ul} = {12'h014, 12'h014, 12'h0C8, 12'h0C8, 12'h320};
        err_total = 0;
        comparisons = 0;
        repeat (8) @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        // back to back: flat edge, third section and unrestrained edge
        step({16'h0000, 16'h0015, 16'h0014}, {3{16'h000A}}, {3{16'h000A}}, {3{16'h0005}});
        step({16'h0281, 16'h0280, 16'h0321}, {3{16'h0258}}, {3{16'h0190}}, 48'h0);
        step({16'h0000, 16'h0000, 16'h0320}, {3{16'h0258}}, {3{16'h0190}}, 48'h0);
        drain("default characteristic");
        wind3 <= 1'b1;
        step(48'h0, {16'h0001, 16'h00FF, 16'hFFFF}, {16'h0002, 16'h0000, 16'hFFFF},
            {16'h0004, 16'h0001, 16'hFFFF});
        drain("three windings");
        wind3 <= 1'b0;
        step(48'h0, {16'h0001, 16'h00FF, 16'hFFFF}, {16'h0002, 16'h0000, 16'hFFFF},
            {16'h0004, 16'h0001, 16'hFFFF});
        drain("two windings");
        blk <= 1'b1;
        step({16'h0000, 16'h0015, 16'h0321}, {3{16'h000A}}, {3{16'h000A}}, 48'h0);
        drain("user block");
        {blk, bs, s1, kn, s2, ul} <= {1'b0, 12'h032, 12'h032, 12'h7D0, 12'h01E, 12'h9C4};
        repeat (3) @(negedge clk);
        step({16'h04E3, 16'h01F4, 16'h09C5}, {16'h0BB8, 16'h04B0, 16'h04B0},
            {16'h07D0, 16'h0320, 16'h0320}, 48'h0);
        drain("setting limits");
        bs <= 12'h005;
        repeat (3) @(negedge clk);
        cmp_flags({9'h000, clamped}, 10'h001);
        step({16'h0000, 16'h000B, 16'h000A}, {3{16'h000A}}, {3{16'h000A}}, 48'h0);
        drain("clamped base");
        rst <= 1'b1;
        repeat (2) @(negedge clk);
        cmp_flags({ri, rv, uv, ug}, 10'h000);
        cmp_bias(bias_w, 51'h0);
        {rst, bs} <= {1'b0, 12'h014};
        repeat (3) @(negedge clk);
        cmp_flags({9'h000, clamped}, 10'h000);
        $display("test reset finished");
        report_and_stop;
    end
endmodule // differential_bias_characteristic_bench
